// ---- sdm_data_memory.v ----
// Data memory address decoder: sectors, pointers, indirect ports, RAM.
// Assumes a core that issues at most one access per clock, same domain.
`timescale 1ns/10ps
`include "sdm_map.vh"

module sdm_data_memory #(
    parameter [127:0] S0_IMPL = `SDM_S0_IMPL,
    parameter [127:0] S1_IMPL = `SDM_S1_IMPL,
    parameter [127:0] S0_RO   = `SDM_S0_RO,
    parameter [127:0] S1_RO   = `SDM_S1_RO
) (
    input  wire                   clk,
    input  wire                   rst,
    input  wire                   req_valid,
    input  wire                   req_extended,
    input  wire [1:0]             req_op,
    input  wire [`SDM_ADDR_W-1:0] req_addr,
    input  wire [2:0]             req_bit,
    input  wire [7:0]             req_wdata,
    output reg                    rsp_valid,
    output reg  [7:0]             rsp_rdata,
    input  wire                   hw_en,
    input  wire                   hw_sector,
    input  wire [`SDM_SFR_W-1:0]  hw_addr,
    input  wire [7:0]             hw_data,
    output reg                    program_bank_select
);

// ****************************************************************
// Helper functions
// ****************************************************************

    // True for the three storage-less port offsets
    function is_port;
        input [7:0] loc;
        begin
            is_port = (loc == `SDM_OFS_PORT_A) ||
                      (loc == `SDM_OFS_PORT_B) ||
                      (loc == `SDM_OFS_PORT_C);
        end
    endfunction

    // Resolve an operand to {null, sector, location}
    function [`SDM_SECTOR_BITS+8:0] resolve;
        input        ext;
        input [10:0] addr;
        input [7:0]  pa;
        input [7:0]  pbl;
        input [7:0]  pbs;
        input [7:0]  pcl;
        input [7:0]  pcs;
        reg   [7:0]  sec;
        reg   [7:0]  loc;
        reg          via_ptr;
        begin
            sec     = `SDM_SECTOR_ZERO;
            loc     = addr[7:0];
            via_ptr = 1'b0;
            if (ext) begin
                sec = {5'h00, addr[10:8]};
            end
            if (sec == `SDM_SECTOR_ZERO && is_port(loc)) begin
                via_ptr = 1'b1;
                case (loc)
                    `SDM_OFS_PORT_A: begin
                        sec = `SDM_SECTOR_ZERO;
                        loc = pa;
                    end
                    `SDM_OFS_PORT_B: begin
                        sec = pbs;
                        loc = pbl;
                    end
                    default: begin
                        sec = pcs;
                        loc = pcl;
                    end
                endcase
            end
            // A pointer aimed at a port, or past the last sector, is void
            resolve = {(via_ptr && sec == `SDM_SECTOR_ZERO && is_port(loc))
                       || (sec > `SDM_SECTOR_LAST),
                       sec[`SDM_SECTOR_BITS-1:0], loc};
        end
    endfunction

// ****************************************************************
// Pointer storage
// ****************************************************************

    reg [7:0] ptr_a;
    reg [7:0] ptr_b_loc;
    reg [7:0] ptr_b_sec;
    reg [7:0] ptr_c_loc;
    reg [7:0] ptr_c_sec;

// ****************************************************************
// Decode of the current request
// ****************************************************************

    wire [`SDM_SECTOR_BITS+8:0] res;
    wire                        acc_null;
    wire [`SDM_SECTOR_BITS-1:0] acc_sec;
    wire [7:0]                  acc_loc;
    wire                        acc_gp;
    wire                        acc_s0;
    wire                        acc_s1;
    wire                        acc_write;
    wire                        is_ptr;
    // Built further down by the read mux and the read-modify-write logic
    reg  [7:0]                  cur_byte;
    reg  [7:0]                  next_byte;

    // Standard operands ignore bits 10..8 and land in sector 0
    assign res = resolve(req_extended, req_addr, ptr_a,
                         ptr_b_loc, ptr_b_sec, ptr_c_loc, ptr_c_sec);
    assign acc_null  = res[`SDM_SECTOR_BITS+8];
    assign acc_sec   = res[`SDM_SECTOR_BITS+7:8];
    assign acc_loc   = res[7:0];
    assign acc_gp    = acc_loc[`SDM_GP_BIT];
    assign acc_s0    = (acc_sec == `SDM_SEC0_IDX);
    assign acc_s1    = (acc_sec == `SDM_SEC1_IDX);
    assign acc_write = req_valid && (req_op != `SDM_OP_READ) && !acc_null;

    assign is_ptr = acc_s0 && !acc_gp &&
                    ((acc_loc == `SDM_OFS_PTR_A) ||
                     (acc_loc == `SDM_OFS_PTR_B_LOC) ||
                     (acc_loc == `SDM_OFS_PTR_B_SEC) ||
                     (acc_loc == `SDM_OFS_PTR_C_LOC) ||
                     (acc_loc == `SDM_OFS_PTR_C_SEC));

// ****************************************************************
// Storage blocks
// ****************************************************************

    wire [7:0] s0_rd;
    wire [7:0] s1_rd;
    wire [7:0] gpr_rd;
    wire [7:0] s0_peek;
    wire [9:0] gpr_idx;
    wire [7:0] bank_sel_ofs;
    wire       s0_wr_en;
    wire       s1_wr_en;
    wire       gpr_wr_en;

    // The sector number selects a whole 128-byte RAM slice
    assign gpr_idx = {acc_sec, acc_loc[6:0]};
    // Offset is a byte wide; the bank peeks with the low seven bits
    assign bank_sel_ofs = `SDM_OFS_BANK_SEL;

    // Pointer bytes live up here, so the core never writes their bank copies
    assign s0_wr_en  = acc_write && !acc_gp && acc_s0 && !is_ptr;
    assign s1_wr_en  = acc_write && !acc_gp && acc_s1;
    assign gpr_wr_en = acc_write && acc_gp;

    // Sector 1 gets its own bank, not an alias of sector 0
    sdm_sfr_bank #(
        .IMPL_MASK (S0_IMPL),
        .RO_MASK   (S0_RO)
    ) u_bank0 (
        .clk       (clk),
        .rst       (rst),
        .rd_addr   (acc_loc[6:0]),
        .rd_data   (s0_rd),
        .peek_addr (bank_sel_ofs[`SDM_SFR_W-1:0]),
        .peek_data (s0_peek),
        .wr_en     (s0_wr_en),
        .wr_addr   (acc_loc[6:0]),
        .wr_data   (next_byte),
        .hw_en     (hw_en && !hw_sector),
        .hw_addr   (hw_addr),
        .hw_data   (hw_data)
    );

    sdm_sfr_bank #(
        .IMPL_MASK (S1_IMPL),
        .RO_MASK   (S1_RO)
    ) u_bank1 (
        .clk       (clk),
        .rst       (rst),
        .rd_addr   (acc_loc[6:0]),
        .rd_data   (s1_rd),
        .peek_addr (7'h00),
        .peek_data (),
        .wr_en     (s1_wr_en),
        .wr_addr   (acc_loc[6:0]),
        .wr_data   (next_byte),
        .hw_en     (hw_en && hw_sector),
        .hw_addr   (hw_addr),
        .hw_data   (hw_data)
    );

    sdm_gpr_ram #(
        .DEPTH  (`SDM_GPR_DEPTH),
        .ADDR_W (`SDM_GPR_ADDR_W)
    ) u_gpr (
        .clk     (clk),
        .rd_addr (gpr_idx),
        .rd_data (gpr_rd),
        .wr_en   (gpr_wr_en),
        .wr_addr (gpr_idx),
        .wr_data (next_byte)
    );

// ****************************************************************
// Read mux and read-modify-write
// ****************************************************************

    always @* begin
        cur_byte = `SDM_ZERO_BYTE;
        if (acc_null) begin
            cur_byte = `SDM_ZERO_BYTE;
        end else if (acc_gp) begin
            cur_byte = gpr_rd;
        end else if (acc_s0) begin
            case (acc_loc)
                `SDM_OFS_PTR_A:     cur_byte = ptr_a;
                `SDM_OFS_PTR_B_LOC: cur_byte = ptr_b_loc;
                `SDM_OFS_PTR_B_SEC: cur_byte = ptr_b_sec;
                `SDM_OFS_PTR_C_LOC: cur_byte = ptr_c_loc;
                `SDM_OFS_PTR_C_SEC: cur_byte = ptr_c_sec;
                default:            cur_byte = s0_rd;
            endcase
        end else if (acc_s1) begin
            cur_byte = s1_rd;
        end
    end

    // Bit operations touch one bit only, the rest are written back
    always @* begin
        case (req_op)
            `SDM_OP_WRITE:   next_byte = req_wdata;
            `SDM_OP_SET_BIT: next_byte = cur_byte | (8'h01 << req_bit);
            `SDM_OP_CLR_BIT: next_byte = cur_byte & ~(8'h01 << req_bit);
            default:         next_byte = cur_byte;
        endcase
    end

// ****************************************************************
// Pointer writes
// ****************************************************************

    always @(posedge clk) begin
        if (rst) begin
            ptr_a     <= `SDM_PTR_RESET;
            ptr_b_loc <= `SDM_PTR_RESET;
            ptr_b_sec <= `SDM_PTR_RESET;
            ptr_c_loc <= `SDM_PTR_RESET;
            ptr_c_sec <= `SDM_PTR_RESET;
        end else if (acc_write && is_ptr) begin
            case (acc_loc)
                `SDM_OFS_PTR_A:     ptr_a     <= next_byte;
                `SDM_OFS_PTR_B_LOC: ptr_b_loc <= next_byte;
                `SDM_OFS_PTR_B_SEC: ptr_b_sec <= next_byte;
                `SDM_OFS_PTR_C_LOC: ptr_c_loc <= next_byte;
                default:            ptr_c_sec <= next_byte;
            endcase
        end
    end

// ****************************************************************
// Response and program bank output
// ****************************************************************

    // Result is registered so the core sees a stable byte one cycle on
    always @(posedge clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= `SDM_ZERO_BYTE;
        end else begin
            rsp_valid <= req_valid;
            if (req_valid) begin
                rsp_rdata <= acc_null ? `SDM_ZERO_BYTE : next_byte;
            end
        end
    end

    // Only feeds program memory, never the sector decode; it lags the
    // stored bit by one cycle, which no data access can observe
    always @(posedge clk) begin
        if (rst) begin
            program_bank_select <= 1'b0;
        end else begin
            program_bank_select <= s0_peek[`SDM_BANK_SEL_BIT];
        end
    end

endmodule

// ---- sdm_map.vh ----
// Constants for the sectored data memory address decoder.
// Assumes inclusion by every design file of the block; definitions only.
`ifndef SDM_MAP_VH
`define SDM_MAP_VH

// ****************************************************************
// Address layout
// ****************************************************************
`define SDM_ADDR_W        11
`define SDM_SECTOR_BITS   3
`define SDM_SECTORS       8
`define SDM_LOC_W         8
`define SDM_SFR_W         7
`define SDM_GP_BIT        7
`define SDM_SFR_DEPTH     128
`define SDM_GPR_DEPTH     1024
`define SDM_SECTOR_ZERO   8'h00
`define SDM_SECTOR_LAST   8'h07
`define SDM_SEC0_IDX      3'h0
`define SDM_SEC1_IDX      3'h1
`define SDM_GPR_ADDR_W    10

// ****************************************************************
// Pointer and indirect port offsets in sector 0
// ****************************************************************
`define SDM_OFS_PORT_A    8'h00
`define SDM_OFS_PTR_A     8'h01
`define SDM_OFS_PORT_B    8'h02
`define SDM_OFS_PTR_B_LOC 8'h03
`define SDM_OFS_PTR_B_SEC 8'h04
`define SDM_OFS_BANK_SEL  8'h0B
`define SDM_OFS_PORT_C    8'h0C
`define SDM_OFS_PTR_C_LOC 8'h0D
`define SDM_OFS_PTR_C_SEC 8'h0E
`define SDM_PTR_RESET     8'h00
`define SDM_ZERO_BYTE     8'h00
`define SDM_BANK_SEL_BIT  0

// ****************************************************************
// Operations from the core
// ****************************************************************
`define SDM_OP_READ       2'h0
`define SDM_OP_WRITE      2'h1
`define SDM_OP_SET_BIT    2'h2
`define SDM_OP_CLR_BIT    2'h3

// ****************************************************************
// Implemented and read-only special locations, one bit per offset
// ****************************************************************
`define SDM_S0_IMPL 128'h01FF_FFFF_FDFF_FFFE_FFFF_FFFF_7FFF_FFFF
`define SDM_S1_IMPL 128'h0000_0000_3FFF_F001_FF80_0000_0000_0000
`define SDM_S0_RO   128'h0000_0000_0000_0000_0000_0003_0000_0000
`define SDM_S1_RO   128'h0000_0000_0000_0000_0000_0000_0000_0000

`endif

// ---- sdm_sfr_bank.v ----
// One sector's set of special locations, offsets 00H..7FH.
// Assumes the parent gates the core write port for the decoded sector.
`timescale 1ns/10ps
`include "sdm_map.vh"

module sdm_sfr_bank #(
    parameter [127:0] IMPL_MASK = `SDM_S0_IMPL,
    parameter [127:0] RO_MASK   = `SDM_S0_RO
) (
    input  wire                  clk,
    input  wire                  rst,
    input  wire [`SDM_SFR_W-1:0] rd_addr,
    output wire [7:0]            rd_data,
    input  wire [`SDM_SFR_W-1:0] peek_addr,
    output wire [7:0]            peek_data,
    input  wire                  wr_en,
    input  wire [`SDM_SFR_W-1:0] wr_addr,
    input  wire [7:0]            wr_data,
    input  wire                  hw_en,
    input  wire [`SDM_SFR_W-1:0] hw_addr,
    input  wire [7:0]            hw_data
);

    reg [7:0] store [0:`SDM_SFR_DEPTH-1];
    integer   i;

    // Unused offsets have no storage behind them and read as 00H
    assign rd_data   = IMPL_MASK[rd_addr] ? store[rd_addr] : `SDM_ZERO_BYTE;
    assign peek_data = IMPL_MASK[peek_addr] ? store[peek_addr]
                                            : `SDM_ZERO_BYTE;

    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < `SDM_SFR_DEPTH; i = i + 1) begin
                store[i] <= `SDM_ZERO_BYTE;
            end
        end else begin
            // Peripheral update wins over a core write in the same cycle
            if (hw_en && IMPL_MASK[hw_addr]) begin
                store[hw_addr] <= hw_data;
            end
            if (wr_en && IMPL_MASK[wr_addr] && !RO_MASK[wr_addr] &&
                !(hw_en && hw_addr == wr_addr)) begin
                store[wr_addr] <= wr_data;
            end
        end
    end

endmodule

// ---- sdm_gpr_ram.v ----
// General purpose RAM of all sectors, locations 80H..FFH of each.
// Assumes the parent supplies a physical index {sector, location[6:0]}.
`timescale 1ns/10ps
`include "sdm_map.vh"

module sdm_gpr_ram #(
    parameter DEPTH  = `SDM_GPR_DEPTH,
    parameter ADDR_W = `SDM_GPR_ADDR_W
) (
    input  wire              clk,
    input  wire [ADDR_W-1:0] rd_addr,
    output wire [7:0]        rd_data,
    input  wire              wr_en,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [7:0]        wr_data
);

    // RAM content is undefined after reset, as in the real array
    reg [7:0] mem [0:DEPTH-1];

    assign rd_data = mem[rd_addr];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule

// ---- sdm_dm_properties.sv ----
// Checker for the sectored data memory decoder, watching its top ports.
// Assumes the default masks: offset 1FH of sector 0 is unused.
`timescale 1ns/10ps
`include "sdm_map.vh"

module sdm_dm_checker (
    input wire        clk,
    input wire        rst,
    input wire        req_valid,
    input wire        req_extended,
    input wire [1:0]  req_op,
    input wire [10:0] req_addr,
    input wire [2:0]  req_bit,
    input wire [7:0]  req_wdata,
    input wire        rsp_valid,
    input wire [7:0]  rsp_rdata,
    input wire        program_bank_select
);
    reg [7:0] wd1, wd2, wd3;
    reg [2:0] bit1;
    reg       clr1;
    wire      s0 = !req_extended || req_addr[10:8] == 3'h0;
    wire      rd = req_valid && req_op == `SDM_OP_READ;
    wire      wr = req_valid && req_op == `SDM_OP_WRITE;

    always @(posedge clk) begin
        wd1 <= req_wdata;
        wd2 <= wd1;
        wd3 <= wd2;
        bit1 <= req_bit;
        clr1 <= req_op[0];
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ************************************************************
    // Properties
    // ************************************************************
    property p_rsp_next;
        req_valid |=> rsp_valid;
    endproperty
    a_rsp_next: assert property (p_rsp_next) else $error("no answer");
    property p_rsp_quiet;
        !req_valid |=> !rsp_valid;
    endproperty
    a_rsp_quiet: assert property (p_rsp_quiet) else $error("stray answer");
    property p_gpr_rw;
        wr && req_addr[7] ##1 !req_valid ##1 rd && req_addr == $past(req_addr, 2)
            && req_extended == $past(req_extended, 2) |=> rsp_rdata == wd3;
    endproperty
    a_gpr_rw: assert property (p_gpr_rw) else $error("ram lost data");
    property p_bit_op;
        req_valid && req_op[1] && req_addr[7] |=> rsp_rdata[bit1] != clr1;
    endproperty
    a_bit_op: assert property (p_bit_op) else $error("bit op wrong");
    property p_unused_s0;
        rd && s0 && req_addr[7:0] == 8'h1F |=> rsp_rdata == `SDM_ZERO_BYTE;
    endproperty
    a_unused_s0: assert property (p_unused_s0) else $error("unused nonzero");
    property p_far_sector;
        rd && req_extended && req_addr[10:9] != 2'h0 && !req_addr[7]
            |=> rsp_rdata == `SDM_ZERO_BYTE;
    endproperty
    a_far_sector: assert property (p_far_sector) else $error("far nonzero");
    property p_ptr_echo;
        wr && s0 && req_addr[7:0] == `SDM_OFS_PTR_A ##1 !req_valid
            ##1 rd && s0 && req_addr[7:0] == `SDM_OFS_PTR_A
            |=> rsp_rdata == wd3;
    endproperty
    a_ptr_echo: assert property (p_ptr_echo) else $error("pointer lost");
    property p_bank_sel;
        wr && s0 && req_addr[7:0] == `SDM_OFS_BANK_SEL
            |-> ##2 program_bank_select == wd2[`SDM_BANK_SEL_BIT];
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank select");
endmodule

bind sdm_data_memory sdm_dm_checker sdm_dm_checker_inst (
    .clk(clk), .rst(rst), .req_valid(req_valid),
    .req_extended(req_extended), .req_op(req_op), .req_addr(req_addr),
    .req_bit(req_bit), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .program_bank_select(program_bank_select));

// ---- sdm_core_model.sv ----
// Core-side model issuing one access at a time to the decoder.
// Assumes the one-cycle answer of the decoder on the same clock.
`timescale 1ns/10ps

module sdm_core_model (
    input  wire        clk,
    output reg         req_valid,
    output reg         req_extended,
    output reg  [1:0]  req_op,
    output reg  [10:0] req_addr,
    output reg  [2:0]  req_bit,
    output reg  [7:0]  req_wdata,
    input  wire        rsp_valid,
    input  wire [7:0]  rsp_rdata
);
    integer gap = 0;

    initial begin
        req_valid = 1'b0;
        req_extended = 1'b0;
        req_op = 2'h0;
        req_addr = 11'h000;
        req_bit = 3'h0;
        req_wdata = 8'h00;
    end

    task access(input [1:0] op, input ext, input [10:0] a, input [2:0] b,
                input [7:0] wd, output [7:0] rd, output ok);
        integer n;
        begin
            repeat (gap) @(posedge clk);
            @(posedge clk);
            req_valid <= 1'b1;
            req_extended <= ext;
            req_op <= op;
            req_addr <= a;
            req_bit <= b;
            req_wdata <= wd;
            @(posedge clk);
            req_valid <= 1'b0;
            // Idle lines show the inverse so a stale value cannot pass
            req_extended <= ~ext;
            req_op <= ~op;
            req_addr <= ~a;
            req_bit <= ~b;
            req_wdata <= ~wd;
            ok = 1'b0;
            for (n = 0; n < 4 && !ok; n = n + 1) begin
                @(negedge clk);
                if (rsp_valid === 1'b1)
                    ok = 1'b1;
            end
            rd = rsp_rdata;
        end
    endtask
endmodule

// ---- sdm_data_memory_test.sv ----
// Self-checking bench for the sectored data memory decoder.
// Assumes default masks and read-only offsets 20H, 21H of sector 0.
`timescale 1ns/10ps
`include "sdm_map.vh"

module sdm_data_memory_test;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         hw_en = 1'b0;
    reg         hw_sector = 1'b0;
    reg  [6:0]  hw_addr = 7'h00;
    reg  [7:0]  hw_data = 8'h00;
    wire        req_valid, req_extended, rsp_valid, program_bank_select;
    wire [1:0]  req_op;
    wire [10:0] req_addr;
    wire [2:0]  req_bit;
    wire [7:0]  req_wdata, rsp_rdata;
    integer     error_cnt = 0;
    integer     checked = 0;
    reg  [7:0]  k, r;
    reg  [83:0] t;

    always #50 clk = ~clk;

    sdm_data_memory sdm_data_memory_inst (.clk(clk), .rst(rst),
        .req_valid(req_valid), .req_extended(req_extended), .req_op(req_op),
        .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .hw_en(hw_en),
        .hw_sector(hw_sector), .hw_addr(hw_addr), .hw_data(hw_data),
        .program_bank_select(program_bank_select));
    sdm_core_model sdm_core_model_inst (.clk(clk), .req_valid(req_valid),
        .req_extended(req_extended), .req_op(req_op), .req_addr(req_addr),
        .req_bit(req_bit), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));

    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task test_done;
        begin
            $display("Counts: %0d errors, %0d checks", error_cnt, checked);
            if (error_cnt == 0 && checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task acc(input [1:0] op, input ext, input [10:0] a, input [2:0] b,
             input [7:0] wd, output [7:0] rd);
        reg ok;
        begin
            sdm_core_model_inst.access(op, ext, a, b, wd, rd, ok);
            if (ok !== 1'b1) begin
                error_cnt = error_cnt + 1;
                test_done;
            end
        end
    endtask
    task wr(input ext, input [10:0] a, input [7:0] d);
        acc(`SDM_OP_WRITE, ext, a, 3'h0, d, r);
    endtask
    task rdc(input ext, input [10:0] a, input [7:0] e);
        begin
            acc(`SDM_OP_READ, ext, a, 3'h0, 8'h00, r);
            chk(r, e);
        end
    endtask
    task hw(input s, input [6:0] a, input [7:0] d);
        begin
            @(posedge clk);
            hw_en <= 1'b1;
            hw_sector <= s;
            hw_addr <= a;
            hw_data <= d;
            @(posedge clk);
            hw_en <= 1'b0;
        end
    endtask

    initial begin
        #(100 * 50000);
        error_cnt = error_cnt + 1;
        test_done;
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t = 84'h001_003_004_00D_00E_000_000;
        for (k = 0; k < 5; k = k + 1)
            wr(0, t[82-12*k -: 11], 8'h21 + k);
        for (k = 0; k < 5; k = k + 1)
            rdc(1, t[82-12*k -: 11], 8'h21 + k);
        wr(0, 11'h001, 8'h80);
        rdc(0, 11'h001, 8'h80);
        wr(0, 11'h000, 8'h5A);
        rdc(0, 11'h080, 8'h5A);
        wr(0, 11'h001, 8'h02);
        rdc(0, 11'h000, 8'h00);
        wr(0, 11'h004, 8'h01);
        wr(0, 11'h003, 8'h80);
        wr(0, 11'h002, 8'hA5);
        rdc(1, 11'h180, 8'hA5);
        rdc(0, 11'h080, 8'h5A);
        wr(0, 11'h00E, 8'h07);
        wr(0, 11'h00D, 8'hFF);
        wr(0, 11'h00C, 8'h3C);
        rdc(1, 11'h7FF, 8'h3C);
        wr(0, 11'h0FF, 8'h12);
        rdc(0, 11'h0FF, 8'h12);
        wr(0, 11'h00E, 8'h08);
        wr(0, 11'h00C, 8'h77);
        rdc(0, 11'h00C, 8'h00);
        rdc(0, 11'h0FF, 8'h12);
        sdm_core_model_inst.gap = 3;
        for (k = 0; k < 8; k = k + 1)
            wr(1, {k[2:0], 8'hC0}, 8'h40 + k);
        sdm_core_model_inst.gap = 0;
        for (k = 0; k < 8; k = k + 1)
            rdc(1, {k[2:0], 8'hC0}, 8'h40 + k);
        wr(0, 11'h1C0, 8'h99);
        rdc(1, 11'h0C0, 8'h99);
        rdc(1, 11'h1C0, 8'h41);
        wr(0, 11'h081, 8'h00);
        acc(`SDM_OP_SET_BIT, 0, 11'h081, 3'h5, 8'h00, r);
        chk(r, 8'h20);
        wr(1, 11'h381, 8'hFF);
        acc(`SDM_OP_CLR_BIT, 1, 11'h381, 3'h0, 8'h00, r);
        rdc(1, 11'h381, 8'hFE);
        t = 84'h01F_040_059_07F_110_141_310;
        for (k = 0; k < 7; k = k + 1) begin
            wr(1, t[82-12*k -: 11], 8'hFF);
            rdc(1, t[82-12*k -: 11], 8'h00);
        end
        wr(0, 11'h037, 8'h44);
        wr(1, 11'h137, 8'h99);
        rdc(0, 11'h037, 8'h44);
        rdc(1, 11'h137, 8'h99);
        hw(1, 7'h37, 8'h3E);
        rdc(1, 11'h137, 8'h3E);
        wr(0, 11'h020, 8'h55);
        rdc(0, 11'h020, 8'h00);
        hw(0, 7'h20, 8'h6B);
        rdc(0, 11'h020, 8'h6B);
        wr(0, 11'h022, 8'h5C);
        rdc(0, 11'h022, 8'h5C);
        wr(0, 11'h00B, 8'h01);
        @(posedge clk);
        @(negedge clk);
        chk({7'h00, program_bank_select}, 8'h01);
        rdc(1, 11'h180, 8'hA5);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(0, 11'h001, 8'h00);
        chk({7'h00, program_bank_select}, 8'h00);
        test_done;
    end
endmodule
